//--- rtl/csrs_top.sv
// Channel sync/reset select logic of a four-channel downconverter.
// Assumes one 200 MHz clock; pins arrive asynchronously, channel
// output strobes come from logic on aclk.
`timescale 1ns/1ps
`include "csrs_map.svh"
module csrs_top #(
    parameter int AW = 18
)
(
    // Clock and bus reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [AW-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [AW-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Device pins
    input wire logic rst_pin_n,
    input wire logic sync_in_pulse,
    // Channel datapath
    input wire logic [3:0] ch_out_strobe,
    output csrs_pkg::csrs_act_t [3:0] chan_act,
    output logic ser_div_reset,
    output logic [3:0] input_enable,
    output logic input_mode_gated,
    // Interrupts
    output logic int_pin,
    output logic irq
);

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Register decode, shared by read and write paths
    function automatic csrs_pkg::csrs_reg_t idx_decode(input logic [AW-1:0] a);
        logic [15:0] idx;
        idx = 16'(a >> 2);
        if (a[1:0] != 2'h0)
            return csrs_pkg::CSRS_R_NONE;
        unique case (idx)
            `CSRS_IDX_ROUTE: return csrs_pkg::CSRS_R_ROUTE;
            `CSRS_IDX_SEL: return csrs_pkg::CSRS_R_SEL;
            `CSRS_IDX_SCLK: return csrs_pkg::CSRS_R_SCLK;
            `CSRS_IDX_CTRL: return csrs_pkg::CSRS_R_CTRL;
            `CSRS_IDX_STAT: return csrs_pkg::CSRS_R_STAT;
            `CSRS_IDX_ISTAT: return csrs_pkg::CSRS_R_ISTAT;
            `CSRS_IDX_IMASK: return csrs_pkg::CSRS_R_IMASK;
            default: return csrs_pkg::CSRS_R_NONE;
        endcase
    endfunction

    // Byte-lane merge of a write into an old word
    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
                r[8*b +: 8] = nw[8*b +: 8];
        end
        return r;
    endfunction

    // Pin synchronisers; only the second stage feeds logic
    logic sync_meta_q, sync_sync_q, sync_prev_q;
    logic rstp_meta_q, rstp_sync_q;
    logic sync_evt, hw_rst;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync_meta_q <= 1'b0;
            sync_sync_q <= 1'b0;
            sync_prev_q <= 1'b0;
            rstp_meta_q <= 1'b0;
            rstp_sync_q <= 1'b0;
        end
        else
        begin
            sync_meta_q <= sync_in_pulse;
            sync_sync_q <= sync_meta_q;
            sync_prev_q <= sync_sync_q;
            rstp_meta_q <= rst_pin_n;
            rstp_sync_q <= rstp_meta_q;
        end
    end

    // One event per rising edge of the sync pin
    assign sync_evt = sync_sync_q & ~sync_prev_q;
    assign hw_rst = ~rstp_sync_q;

    // Write channel state
    logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
    logic awready_q, awready_d, wready_q, wready_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic [AW-1:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic wr_fire;
    csrs_pkg::csrs_reg_t wr_reg;

    assign wr_reg = idx_decode(awaddr_q);
    assign wr_fire = aw_hold_q & w_hold_q & ~bvalid_q;

    // Address and data taken in either order; response after both
    always_comb
    begin
        aw_hold_d = aw_hold_q;
        w_hold_d = w_hold_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        if (s_axi_awvalid && awready_q)
        begin
            aw_hold_d = 1'b1;
            awaddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_q)
        begin
            w_hold_d = 1'b1;
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
        end
        if (wr_fire)
        begin
            aw_hold_d = 1'b0;
            w_hold_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = (wr_reg == csrs_pkg::CSRS_R_NONE) ? RESP_SLVERR : RESP_OKAY;
        end
        if (bvalid_q && s_axi_bready)
            bvalid_d = 1'b0;
        awready_d = ~aw_hold_d & ~bvalid_d;
        wready_d = ~w_hold_d & ~bvalid_d;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            awaddr_q <= '0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end
        else
        begin
            aw_hold_q <= aw_hold_d;
            w_hold_q <= w_hold_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
        end
    end

    // Software-visible registers
    logic [31:0] sel_q, sel_d;
    logic [3:0] pw_q, pw_d;
    logic [5:0] sclk_q, sclk_d;
    logic [3:0] cph_q, cph_d, tph_q, tph_d;
    logic gated_q, gated_d;
    logic [2:0] istat_q, istat_d, imask_q, imask_d;
    logic [31:0] old_word, new_word;
    logic sw_rst;
    logic [3:0] en_q, fir_busy, fir_done, ser_sel, int_sel_vec;
    logic [3:0] ipc_q, ipc_d;
    logic int_evt;

    // Current contents of a register, for reads and merges
    function automatic logic [31:0] rd_word(input csrs_pkg::csrs_reg_t r);
        unique case (r)
            csrs_pkg::CSRS_R_NONE: return 32'h0000_0000;
            csrs_pkg::CSRS_R_ROUTE: return {8'h00, pw_q, 20'h00000};
            csrs_pkg::CSRS_R_SEL: return sel_q;
            csrs_pkg::CSRS_R_SCLK: return {26'h0000000, sclk_q};
            csrs_pkg::CSRS_R_CTRL: return {20'h00000, tph_q, cph_q, 4'h0};
            csrs_pkg::CSRS_R_STAT: return {22'h000000, int_pin, gated_q, fir_busy, en_q};
            csrs_pkg::CSRS_R_ISTAT: return {29'h00000000, istat_q};
            csrs_pkg::CSRS_R_IMASK: return {29'h00000000, imask_q};
        endcase
    endfunction

    always_comb old_word = rd_word(wr_reg); // Follows register contents, not only the index
    assign new_word = wmerge(old_word, wdata_q, wstrb_q);
    // Software reset of the processor: a write pulse only
    assign sw_rst = wr_fire & (wr_reg == csrs_pkg::CSRS_R_CTRL) & wstrb_q[0] & wdata_q[`CSRS_SWRST_BIT];

    // Register writes; hardware-set status wins over a clear
    always_comb
    begin
        sel_d = sel_q;
        pw_d = pw_q;
        sclk_d = sclk_q;
        cph_d = cph_q;
        tph_d = tph_q;
        gated_d = gated_q;
        imask_d = imask_q;
        istat_d = istat_q;
        if (wr_fire)
        begin
            unique case (wr_reg)
                csrs_pkg::CSRS_R_SEL: sel_d = new_word;
                csrs_pkg::CSRS_R_ROUTE: pw_d = new_word[`CSRS_PW_LSB +: `CSRS_PW_W];
                csrs_pkg::CSRS_R_SCLK: sclk_d = new_word[5:0];
                csrs_pkg::CSRS_R_CTRL:
                begin
                    cph_d = new_word[`CSRS_CPH_LSB +: 4];
                    tph_d = new_word[`CSRS_TPH_LSB +: 4];
                    if (new_word[`CSRS_UNGATE_BIT])
                        gated_d = 1'b0;
                end
                csrs_pkg::CSRS_R_ISTAT: istat_d = istat_q & ~(wdata_q[2:0] & {3{wstrb_q[0]}});
                csrs_pkg::CSRS_R_IMASK: imask_d = new_word[2:0];
                csrs_pkg::CSRS_R_NONE,
                csrs_pkg::CSRS_R_STAT: ;
            endcase
        end
        if (hw_rst)
            gated_d = 1'b1;
        istat_d = istat_d | {|fir_done, int_evt, sync_evt};
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sel_q <= `CSRS_SEL_RST;
            pw_q <= `CSRS_PW_RST;
            sclk_q <= `CSRS_SCLK_RST;
            cph_q <= 4'h0;
            tph_q <= 4'h0;
            gated_q <= 1'b1;
            istat_q <= 3'h0;
            imask_q <= 3'h0;
        end
        else
        begin
            sel_q <= sel_d;
            pw_q <= pw_d;
            sclk_q <= sclk_d;
            cph_q <= cph_d;
            tph_q <= tph_d;
            gated_q <= gated_d;
            istat_q <= istat_d;
            imask_q <= imask_d;
        end
    end

    // Per-channel actions; every channel sees the same sync event
    genvar c;
    generate
        for (c = 0; c < 4; c++)
        begin : g_ch
            csrs_pkg::csrs_sel_t s;
            csrs_pkg::csrs_act_t act_d;
            logic en_d;
            logic [5:0] cnt_q, cnt_d;

            assign s = csrs_pkg::csrs_sel_t'(sel_q[`CSRS_CH_W*(3-c) +: `CSRS_CH_W]);
            assign ser_sel[c] = s.ser_rst;
            assign int_sel_vec[c] = s.int_sel;
            assign fir_busy[c] = (cnt_q != 6'h00);
            assign fir_done[c] = (cnt_q == 6'h01);

            always_comb
            begin
                en_d = en_q[c];
                if (hw_rst)
                    en_d = 1'b0;
                else if (sw_rst && s.hold)
                    en_d = 1'b0;
                else if (sync_evt)
                    en_d = 1'b1;
                cnt_d = cnt_q;
                if (sync_evt && s.fir_rst)
                    cnt_d = `CSRS_FIR_RST_CYCLES;
                else if (cnt_q != 6'h00)
                    cnt_d = cnt_q - 6'h01;
                act_d.fir_reset = (cnt_d != 6'h00);
                act_d.carrier_load = sync_evt & s.carrier_upd;
                // Phase clear only when the per-channel option is on
                act_d.carrier_phase_clr = sync_evt & s.carrier_upd & cph_q[c];
                act_d.timing_load = sync_evt & s.timing_upd;
                act_d.timing_phase_clr = sync_evt & s.timing_upd & tph_q[c];
                act_d.agc_reset = sync_evt & s.agc_rst;
                act_d.cic_reset = sync_evt & s.cic_rst;
                act_d.serial_reset = sync_evt & s.ser_rst;
            end

            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    en_q[c] <= 1'b0;
                    cnt_q <= 6'h00;
                    chan_act[c] <= '0;
                end
                else
                begin
                    en_q[c] <= en_d;
                    cnt_q <= cnt_d;
                    chan_act[c] <= act_d;
                end
            end
        end
    endgenerate

    // Interrupt pulse counter; software and sync never touch it
    assign int_evt = |(ch_out_strobe & int_sel_vec);

    always_comb
    begin
        ipc_d = ipc_q;
        if (hw_rst)
            ipc_d = 4'h0;
        else if (int_evt)
            ipc_d = (pw_q == 4'h0) ? 4'h1 : pw_q;
        else if (ipc_q != 4'h0)
            ipc_d = ipc_q - 4'h1;
    end

    // Outputs registered straight from their next values
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ipc_q <= 4'h0;
            int_pin <= 1'b0;
            irq <= 1'b0;
            ser_div_reset <= 1'b0;
            input_mode_gated <= 1'b1;
            input_enable <= 4'h0;
        end
        else
        begin
            ipc_q <= ipc_d;
            int_pin <= (ipc_d != 4'h0);
            irq <= |(istat_d & imask_d);
            ser_div_reset <= sync_evt & sclk_q[`CSRS_SDIV_BIT] & (|ser_sel);
            input_mode_gated <= gated_d;
            input_enable <= {g_ch[3].en_d, g_ch[2].en_d, g_ch[1].en_d, g_ch[0].en_d};
        end
    end

    // Read channel: one read at a time, answer one cycle after address
    logic arready_q, arready_d, rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;
    csrs_pkg::csrs_reg_t rd_reg;

    assign rd_reg = idx_decode(s_axi_araddr);

    always_comb
    begin
        arready_d = arready_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (s_axi_arvalid && arready_q)
        begin
            arready_d = 1'b0;
            rvalid_d = 1'b1;
            rdata_d = rd_word(rd_reg);
            rresp_d = (rd_reg == csrs_pkg::CSRS_R_NONE) ? RESP_SLVERR : RESP_OKAY;
        end
        else if (rvalid_q && s_axi_rready)
        begin
            rvalid_d = 1'b0;
            arready_d = 1'b1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
        end
        else
        begin
            arready_q <= arready_d | (~arready_q & ~rvalid_q);
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

endmodule

//--- shared/csrs_map.svh
// Register indices, field positions, reset values and counts of the
// channel sync/reset select block.
// Assumes byte address = 4 * register index on a 32-bit AXI4-Lite bus.
// Functional notes
// - Interrupt-select bit: interrupt per channel output sample
// - Input-hold bit: software reset zeroes, holds input enable
// - Reset pin always holds enable, forces gated mode
// - Enable released on the sample with sync
// - Carrier-update bit: load frequency on sync pulse
// - Phase-clear option zeroes carrier phase on load
// - Without phase-clear, loads keep accumulators running continuously
// - FIR-reset bit: sync resets FIR compute engine
// - FIR engine reset lasts 32 input clocks
// - AGC-reset bit: sync resets AGC loop
// - Timing-update bit: resampler oscillator loads on sync
// - Decimation-reset bit: sync resets CIC counter
// - Serial-reset bit: sync resets serial output block
// - Divider-reset enable: serial reset also resets divider
// - Four identical 8-bit fields, channel 0 highest
// - Interrupt pin pulses 1 to 15 clocks
// - Only the reset pin clears the pulse counter
`ifndef CSRS_MAP_SVH
`define CSRS_MAP_SVH

// Register indices
`define CSRS_IDX_ROUTE 16'hf801
`define CSRS_IDX_SEL 16'hf802
`define CSRS_IDX_SCLK 16'hf803
`define CSRS_IDX_CTRL 16'hf810
`define CSRS_IDX_STAT 16'hf811
`define CSRS_IDX_ISTAT 16'hf812
`define CSRS_IDX_IMASK 16'hf813

// Field positions
`define CSRS_CH_W 8
`define CSRS_PW_LSB 20
`define CSRS_PW_W 4
`define CSRS_SDIV_BIT 4
`define CSRS_SWRST_BIT 0
`define CSRS_UNGATE_BIT 1
`define CSRS_CPH_LSB 4
`define CSRS_TPH_LSB 8

// Reset values and counts
`define CSRS_SEL_RST 32'h0000_0000
`define CSRS_PW_RST 4'h1
`define CSRS_SCLK_RST 6'h00
`define CSRS_FIR_RST_CYCLES 6'h20

`endif

//--- shared/csrs_pkg.sv
// Types of the channel sync/reset select block.
// Assumes csrs_map.svh for all numeric constants.
package csrs_pkg;

    // One channel field of the select register, msb first
    typedef struct packed {
        logic int_sel;
        logic hold;
        logic carrier_upd;
        logic fir_rst;
        logic agc_rst;
        logic timing_upd;
        logic cic_rst;
        logic ser_rst;
    } csrs_sel_t;

    // Actions driven into one channel's datapath
    typedef struct packed {
        logic carrier_load;
        logic carrier_phase_clr;
        logic timing_load;
        logic timing_phase_clr;
        logic fir_reset;
        logic agc_reset;
        logic cic_reset;
        logic serial_reset;
    } csrs_act_t;

    // Decoded register
    typedef enum logic [2:0] {
        CSRS_R_NONE,
        CSRS_R_ROUTE,
        CSRS_R_SEL,
        CSRS_R_SCLK,
        CSRS_R_CTRL,
        CSRS_R_STAT,
        CSRS_R_ISTAT,
        CSRS_R_IMASK
    } csrs_reg_t;

endpackage

//--- sim/csrs_far_model.sv
// Far-side model: sync pin source and channel output sample strobes.
// Assumes the bench calls its tasks; it drives only just after rising edges.
`timescale 1ns/1ps
module csrs_far_model
(
    // Clock
    input wire logic aclk,
    // Pulses towards the block
    output logic sync_in_pulse,
    output logic [3:0] ch_out_strobe
);
    // Quiet at time zero
    initial
    begin
        sync_in_pulse = 1'b0;
        ch_out_strobe = 4'h0;
    end

    // Pin held four cycles so the pin synchroniser cannot miss it
    task automatic sync_pulse();
        @(posedge aclk);
        sync_in_pulse <= 1'b1;
        repeat (4) @(posedge aclk);
        sync_in_pulse <= 1'b0;
        repeat (8) @(posedge aclk); // Low gap re-arms the edge detector
    endtask

    // One-cycle output sample strobe
    task automatic strobe(input logic [3:0] m);
        @(posedge aclk);
        ch_out_strobe <= m;
        @(posedge aclk);
        ch_out_strobe <= 4'h0;
    endtask
endmodule

//--- sim/csrs_asserts.sv
// Port assertions of the channel sync/reset select block.
// Assumes one aclk domain with synchronous active-low aresetn.
`timescale 1ns/1ps
module csrs_asserts
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Pins and channel strobes
    input wire logic rst_pin_n,
    input wire logic sync_in_pulse,
    input wire logic [3:0] ch_out_strobe,
    // Actions and interrupt
    input wire csrs_pkg::csrs_act_t [3:0] chan_act,
    input wire logic ser_div_reset,
    input wire logic [3:0] input_enable,
    input wire logic input_mode_gated,
    input wire logic int_pin
);
    localparam logic [31:0] PULSE_M = 32'hf7f7_f7f7;
    logic [5:0] seen_q, seen_d;
    logic [7:0] fir_q, fir_d;

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Recent pin activity; run length of the ch0 FIR reset level
    always_comb
    begin
        seen_d = {seen_q[4:0], sync_in_pulse};
        fir_d = chan_act[0].fir_reset ? fir_q + 8'h01 : 8'h00;
    end

    // Helpers cleared with the bus reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            seen_q <= 6'h00;
            fir_q <= 8'h00;
        end
        else
        begin
            seen_q <= seen_d;
            fir_q <= fir_d;
        end
    end

    a_act_cause: assert property (|(chan_act & PULSE_M) |-> |seen_q)
        else $error("action pulse without sync pin activity");
    a_pulse_single: assert property (!(|(chan_act & $past(chan_act) & PULSE_M)))
        else $error("action pulse longer than one cycle");
    a_fir_len: assert property ($fell(chan_act[0].fir_reset) |-> fir_q >= 8'h20)
        else $error("fir reset shorter than 32 cycles");
    a_fir_cause: assert property ($rose(chan_act[0].fir_reset) |-> |seen_q)
        else $error("fir reset without sync");
    a_phase_load: assert property (chan_act[0].carrier_phase_clr |-> chan_act[0].carrier_load)
        else $error("carrier phase clear without load");
    a_tphase_load: assert property (chan_act[1].timing_phase_clr |-> chan_act[1].timing_load)
        else $error("timing phase clear without load");
    a_div_with_ser: assert property (ser_div_reset |-> |(chan_act & 32'h0101_0101))
        else $error("divider reset without serial reset");
    a_hw_hold: assert property (!rst_pin_n [*5] |-> input_enable == 4'h0 && input_mode_gated)
        else $error("reset pin did not hold the input");
    a_en_cause: assert property (|(input_enable & ~$past(input_enable)) |-> |seen_q)
        else $error("input enable released without sync");
    a_int_cause: assert property ($rose(int_pin) |-> $past(ch_out_strobe) != 4'h0)
        else $error("interrupt pulse without output strobe");
endmodule

bind csrs_top csrs_asserts u_chk (.*);

//--- sim/tb_top.sv
// Self-checking bench of the channel sync/reset select block.
// Assumes csrs_top with default AW, the far model and the bound checker.
`timescale 1ns/1ps
`include "csrs_map.svh"
module tb_top;
    logic aclk, aresetn, rst_pin_n, sync_in_pulse, ser_div_reset, input_mode_gated, int_pin, irq, sdiv;
    logic [17:0] s_axi_awaddr, s_axi_araddr;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata, rnd, sel;
    logic [3:0] s_axi_wstrb, ch_out_strobe, input_enable;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [11:0] ctl;
    logic [7:0] cnt;
    csrs_pkg::csrs_act_t [3:0] chan_act;
    logic [33:0] rq[$];
    logic [32:0] sq[$];
    int fail_count, compares;

    csrs_top dut (.*);
    csrs_far_model far (.aclk(aclk), .sync_in_pulse(sync_in_pulse), .ch_out_strobe(ch_out_strobe));

    // 200 MHz clock
    initial
    begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // Expected divider reset and channel actions for one sync event
    function automatic logic [32:0] exp_act(input logic [31:0] s, input logic [11:0] c, input logic d);
        csrs_pkg::csrs_act_t [3:0] a;
        csrs_pkg::csrs_sel_t f;
        logic sd;
        sd = 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            f = s[31-8*i -: 8];
            a[i] = {f.carrier_upd, f.carrier_upd & c[4+i], f.timing_upd, f.timing_upd & c[8+i],
                    f.fir_rst, f.agc_rst, f.cic_rst, f.ser_rst};
            sd = sd | f.ser_rst;
        end
        return {sd & d, a};
    endfunction

    // AXI4-Lite write: both halves offered together, each released when taken
    task automatic wr(input logic [15:0] idx, input logic [31:0] d);
        logic a, w;
        a = 1'b1;
        w = 1'b1;
        @(posedge aclk);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (a || w)
        begin
            @(posedge aclk);
            if (a && s_axi_awready)
            begin
                a = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w && s_axi_wready)
            begin
                w = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        chk(64'(s_axi_bresp), 64'h0);
        s_axi_bready <= 1'b0;
    endtask

    // AXI4-Lite read; the expected response goes to the queue first
    task automatic rd(input logic [15:0] idx, input logic [33:0] e);
        rq.push_back(e);
        @(posedge aclk);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
    endtask

    // Counts interrupt pin cycles over a window longer than the widest pulse
    task automatic count_int(input logic [7:0] w);
        cnt = 8'h00;
        repeat (20)
        begin
            @(posedge aclk);
            cnt = cnt + 8'(int_pin);
        end
        chk(64'(cnt), 64'(w));
    endtask

    // Monitor: read responses and sync actions against the oldest note
    always @(posedge aclk)
    begin
        if (aresetn && s_axi_rvalid && s_axi_rready)
            chk(64'({s_axi_rresp, s_axi_rdata}), 64'(rq.size() ? rq.pop_front() : 34'hx));
        if (aresetn && |(chan_act & 32'hf7f7_f7f7))
            chk(64'({ser_div_reset, chan_act}), 64'(sq.size() ? sq.pop_front() : 33'hx));
    end

    // Hang guard
    initial
    begin
        repeat (8000) @(posedge aclk);
        fail_count++;
        end_of_test();
    end

    // Main sequence
    initial
    begin
        {aresetn, s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
        rst_pin_n = 1'b1;
        fail_count = 0;
        compares = 0;
        rnd = 32'hee7af3a9;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        rd(`CSRS_IDX_SEL, {2'b00, `CSRS_SEL_RST});
        rd(`CSRS_IDX_ROUTE, 34'h0_0010_0000);
        rd(16'hf800, 34'h2_0000_0000);
        // Random fields, phase-clear options and divider enable
        for (int i = 0; i < 6; i++)
        begin
            rnd = lfsr(lfsr(rnd));
            sel = (rnd & 32'h7f7f_7f7f) | 32'h0101_0101;
            ctl = {rnd[27:20], 4'h0};
            sdiv = rnd[9];
            wr(`CSRS_IDX_SEL, sel);
            wr(`CSRS_IDX_CTRL, {20'h0, ctl});
            wr(`CSRS_IDX_SCLK, {27'h0, sdiv, 4'h0});
            rd(`CSRS_IDX_SEL, {2'b00, sel});
            sq.push_back(exp_act(sel, ctl, sdiv));
            far.sync_pulse();
            chk(64'(input_enable), 64'hf);
            // Let the 32-cycle FIR reset run out before the next sync
            repeat (24) @(posedge aclk);
        end
        // Software reset holds channels 0 and 2 only
        wr(`CSRS_IDX_SEL, 32'h4000_4000);
        wr(`CSRS_IDX_CTRL, 32'h3);
        repeat (2) @(posedge aclk);
        chk(64'({input_mode_gated, input_enable}), 64'h0a);
        far.sync_pulse();
        chk(64'(input_enable), 64'hf);
        // Reset pin holds all and sets gated mode
        rst_pin_n <= 1'b0;
        repeat (6) @(posedge aclk);
        chk(64'({input_mode_gated, input_enable}), 64'h10);
        rst_pin_n <= 1'b1;
        repeat (6) @(posedge aclk);
        chk(64'(input_enable), 64'h0);
        far.sync_pulse();
        chk(64'(input_enable), 64'hf);
        // Interrupt select on channel 1 only, widths 1, 8 and 15
        wr(`CSRS_IDX_SEL, 32'h0080_0000);
        far.strobe(4'b0001);
        count_int(8'h00);
        for (int w = 1; w < 16; w += 7)
        begin
            wr(`CSRS_IDX_ROUTE, 32'(w) << 20);
            far.strobe(4'b0010);
            count_int(8'(w));
        end
        // A sync with serial reset does not cut a running pulse
        wr(`CSRS_IDX_SEL, 32'h0081_0000);
        sq.push_back(exp_act(32'h0081_0000, 12'h000, sdiv));
        far.strobe(4'b0010);
        fork
            far.sync_pulse();
            count_int(8'h0f);
        join
        // Status raised, masked, unmasked and cleared
        wr(`CSRS_IDX_IMASK, 32'h2);
        repeat (2) @(posedge aclk);
        chk(64'(irq), 64'h1);
        wr(`CSRS_IDX_IMASK, 32'h0);
        repeat (2) @(posedge aclk);
        chk(64'(irq), 64'h0);
        wr(`CSRS_IDX_IMASK, 32'h2);
        wr(`CSRS_IDX_ISTAT, 32'h7);
        repeat (2) @(posedge aclk);
        chk(64'(irq), 64'h0);
        rd(`CSRS_IDX_ISTAT, 34'h0);
        repeat (4) @(posedge aclk);
        chk(64'(rq.size() + sq.size()), 64'h0);
        end_of_test();
    end
endmodule
